// file: rtl/fevc_pkg.sv
/*
 * Constants for the erase-verify command sequencer: register offsets,
 * field positions, command codes, memory map limits and state codes.
 * Assumes an APB master with 32-bit data and one aligned word per register.
 */
package fevc_pkg;
    // ========================================================
    // register offsets (byte addresses)
    localparam logic [7:0] ADDR_CMD0   = 8'h00;
    localparam logic [7:0] ADDR_CMD1   = 8'h04;
    localparam logic [7:0] ADDR_CMD2   = 8'h08;
    localparam logic [7:0] ADDR_INDEX  = 8'h0c;
    localparam logic [7:0] ADDR_STAT   = 8'h10;
    localparam logic [7:0] ADDR_MODE   = 8'h14;
    localparam logic [7:0] ADDR_IRQST  = 8'h18;
    localparam logic [7:0] ADDR_IRQCLR = 8'h1c;
    localparam logic [7:0] ADDR_IRQEN  = 8'h20;
    localparam logic [7:0] ADDR_ERRINJ = 8'h24;
    // ========================================================
    // status register bits
    localparam int STAT_CCF  = 7;
    localparam int STAT_ACC  = 5;
    localparam int STAT_PROT = 4;
    localparam int STAT_VHI  = 1;
    localparam int STAT_VLO  = 0;
    // irq bits: 0 complete, 1 access error, 2 verify fail
    localparam int IRQ_W = 3;
    // ========================================================
    // command codes and index values
    localparam logic [7:0] CMD_EV_BLOCK = 8'h01;
    localparam logic [7:0] CMD_EV_PSEC  = 8'h03;
    localparam logic [7:0] CMD_EV_ESEC  = 8'h10;
    localparam logic [2:0] IDX_BLOCK    = 3'h1;
    localparam logic [2:0] IDX_SECTION  = 3'h2;
    // ========================================================
    // global memory map (address ranges, inclusive start / exclusive end)
    localparam logic [23:0] PF_START = 24'he80000;
    localparam logic [24:0] PF_END   = 25'h1000000;
    localparam logic [23:0] EE_START = 24'h100000;
    localparam logic [24:0] EE_END   = 25'h100800;
    localparam logic [7:0]  PF_HI    = 8'he8;
    localparam logic [7:0]  EE_HI    = 8'h10;
    // phrase is 8 bytes, word 2 bytes
    localparam int PHRASE_SH = 3;
    localparam int WORD_SH   = 1;
    // ========================================================
    // reset values
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;
    localparam logic        RST_CCF  = 1'b1;
    typedef enum logic [2:0] {
        FEVC_IDLE  = 3'b001,
        FEVC_SCAN  = 3'b010,
        FEVC_DONE  = 3'b100
    } fevc_state_t;
endpackage

// file: rtl/fevc_top.sv
/*
 * Erase-verify command sequencer with APB register slave and interrupt.
 * Assumes an APB master on CLK_I; memory read results arrive on
 * MEM_* inputs, one location per cycle, in the same cycle as MEM_REQ_O.
 */
// What this block does
// - block verify raises access error unless index is 001 at launch
// - any read error during verify sets the upper verify status bit
// - uncorrectable error or blank fail sets the lower verify status bit
// - clearing complete flag starts section verify; flag sets when done
// - non-erased location sets both verify status bits
// - section verifies raise access error unless index is 010
// - section verify in disallowed mode raises access error
// - invalid 24-bit global address raises access error
// - flash section start not phrase aligned raises access error
// - flash section crossing flash end raises access error
// - eeprom section verify checks words and sets complete flag at end
// - eeprom start address with bit 0 set raises access error
// - eeprom range past block end raises access error
`timescale 1ns/1ps
module fevc_top (
    input  wire logic        CLK_I,
    input  wire logic        RST_N_I,
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [7:0]  PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    output logic      [31:0] PRDATA_O,
    output logic             PREADY_O,
    output logic             PSLVERR_O,
    input  wire logic        MEM_BLANK_I,
    input  wire logic        MEM_ERR_I,
    input  wire logic        MEM_UNCORR_I,
    output logic             MEM_REQ_O,
    output logic      [23:0] MEM_ADDR_O,
    output logic             IRQ_O
);
    default clocking fevc_cb @(posedge CLK_I);
    endclocking
    default disable iff (!RST_N_I);
    // ========================================================
    // functions
    function automatic logic in_range(input logic [23:0] a,
                                      input logic [24:0] n,
                                      input logic [23:0] lo,
                                      input logic [24:0] hi);
        logic [24:0] e;
        e = {1'b0, a} + n;
        in_range = ({1'b0, a} >= {1'b0, lo}) && (e <= hi);
    endfunction

    // ========================================================
    // registers
    logic [15:0] cmd0_q, cmd0_d, cmd1_q, cmd1_d, cmd2_q, cmd2_d;
    logic [2:0]  index_q, index_d;
    logic        ccf_q, ccf_d, acc_q, acc_d, vhi_q, vhi_d, vlo_q, vlo_d;
    logic        mode_q, mode_d;
    localparam int IRQ_W_L = fevc_pkg::IRQ_W;
    logic [IRQ_W_L-1:0] irq_st_q, irq_st_d, irq_en_q, irq_en_d;
    logic [31:0] rdata_q, rdata_d;
    logic        ready_q, ready_d, slverr_q, slverr_d, irq_q, irq_d;
    logic        req_q, req_d;
    logic [23:0] addr_q, addr_d;
    logic [15:0] left_q, left_d;
    logic [1:0]  step_q, step_d;
    fevc_pkg::fevc_state_t st_q, st_d;

    // ========================================================
    // launch decode and parameter checks
    logic        setup, wr_acc, rd_acc, launch, acc_err, is_blk, is_pf;
    logic [23:0] gaddr;
    logic [24:0] span;
    logic        mapped;
    assign setup  = PSEL_I && !PENABLE_I;
    assign wr_acc = setup && PWRITE_I;
    assign rd_acc = setup && !PWRITE_I;
    assign launch = wr_acc && PADDR_I == fevc_pkg::ADDR_STAT
                    && PWDATA_I[fevc_pkg::STAT_CCF] && ccf_q;
    assign is_blk = cmd0_q[15:8] == fevc_pkg::CMD_EV_BLOCK;
    assign is_pf  = cmd0_q[15:8] == fevc_pkg::CMD_EV_PSEC;
    assign gaddr  = {cmd0_q[7:0], cmd1_q};
    assign span   = is_pf ? {6'h0, cmd2_q, 3'h0} : {8'h0, cmd2_q, 1'b0};
    assign mapped = (cmd0_q[7:0] >= fevc_pkg::PF_HI)
                    || (cmd0_q[7:0] == fevc_pkg::EE_HI
                        && cmd1_q < 16'h0800);
    always_comb begin
        acc_err = 1'b0;
        if (is_blk) begin
            if (index_q != fevc_pkg::IDX_BLOCK) acc_err = 1'b1;
            if (!mapped) acc_err = 1'b1;
        end else begin
            if (index_q != fevc_pkg::IDX_SECTION) acc_err = 1'b1;
            if (!mode_q) acc_err = 1'b1;
            if (!mapped) acc_err = 1'b1;
            if (is_pf) begin
                if (gaddr[2:0] != 3'h0) acc_err = 1'b1;
                if (!in_range(gaddr, span, fevc_pkg::PF_START,
                              fevc_pkg::PF_END)) acc_err = 1'b1;
            end else begin
                if (gaddr[0]) acc_err = 1'b1;
                if (!in_range(gaddr, span, fevc_pkg::EE_START,
                              fevc_pkg::EE_END)) acc_err = 1'b1;
            end
        end
    end

    // ========================================================
    // next-state logic
    always_comb begin
        cmd0_d = cmd0_q; cmd1_d = cmd1_q; cmd2_d = cmd2_q;
        index_d = index_q; mode_d = mode_q; irq_en_d = irq_en_q;
        ccf_d = ccf_q; acc_d = acc_q; vhi_d = vhi_q; vlo_d = vlo_q;
        irq_st_d = irq_st_q;
        st_d = st_q; req_d = 1'b0; addr_d = addr_q; left_d = left_q;
        step_d = step_q;
        ready_d = setup; slverr_d = 1'b0; rdata_d = fevc_pkg::RST_ZERO;
        if (wr_acc && ccf_q) begin
            case (PADDR_I)
                fevc_pkg::ADDR_CMD0:  cmd0_d  = PWDATA_I[15:0];
                fevc_pkg::ADDR_CMD1:  cmd1_d  = PWDATA_I[15:0];
                fevc_pkg::ADDR_CMD2:  cmd2_d  = PWDATA_I[15:0];
                fevc_pkg::ADDR_INDEX: index_d = PWDATA_I[2:0];
                fevc_pkg::ADDR_MODE:  mode_d  = PWDATA_I[0];
                default: ;
            endcase
        end
        if (wr_acc && PADDR_I == fevc_pkg::ADDR_IRQEN)
            irq_en_d = PWDATA_I[IRQ_W_L-1:0];
        if (wr_acc && PADDR_I == fevc_pkg::ADDR_IRQCLR)
            irq_st_d = irq_st_q & ~PWDATA_I[IRQ_W_L-1:0];
        if (wr_acc && PADDR_I == fevc_pkg::ADDR_STAT
            && PWDATA_I[fevc_pkg::STAT_ACC])
            acc_d = 1'b0;
        if (rd_acc) begin
            case (PADDR_I)
                fevc_pkg::ADDR_CMD0:  rdata_d = {16'h0, cmd0_q};
                fevc_pkg::ADDR_CMD1:  rdata_d = {16'h0, cmd1_q};
                fevc_pkg::ADDR_CMD2:  rdata_d = {16'h0, cmd2_q};
                fevc_pkg::ADDR_INDEX: rdata_d = {29'h0, index_q};
                fevc_pkg::ADDR_STAT:  rdata_d = {24'h0, ccf_q, 1'b0, acc_q,
                                                 3'h0, vhi_q, vlo_q};
                fevc_pkg::ADDR_MODE:  rdata_d = {31'h0, mode_q};
                fevc_pkg::ADDR_IRQST: rdata_d = {29'h0, irq_st_q};
                fevc_pkg::ADDR_IRQEN: rdata_d = {29'h0, irq_en_q};
                fevc_pkg::ADDR_IRQCLR: rdata_d = fevc_pkg::RST_ZERO;
                default:              slverr_d = 1'b1;
            endcase
        end
        if (wr_acc && PADDR_I > fevc_pkg::ADDR_IRQEN) slverr_d = 1'b1;
        case (st_q)
            fevc_pkg::FEVC_IDLE: begin
                if (launch) begin
                    ccf_d = 1'b0;
                    vhi_d = 1'b0;
                    vlo_d = 1'b0;
                    if (acc_err) begin
                        acc_d = 1'b1;
                        st_d = fevc_pkg::FEVC_DONE;
                    end else begin
                        st_d = fevc_pkg::FEVC_SCAN;
                        addr_d = is_blk ? {cmd0_q[7:0], 16'h0} : gaddr;
                        left_d = is_blk ? 16'h0100 : cmd2_q;
                        step_d = 2'h0;
                    end
                end
            end
            fevc_pkg::FEVC_SCAN: begin
                if (step_q != 2'h0) begin
                    if (MEM_ERR_I || !MEM_BLANK_I) vhi_d = 1'b1;
                    if (MEM_UNCORR_I || !MEM_BLANK_I)
                        vlo_d = 1'b1;
                end
                if (left_q == 16'h0) begin
                    st_d = fevc_pkg::FEVC_DONE;
                    step_d = 2'h0;
                end else begin
                    req_d = 1'b1;
                    if (step_q != 2'h0)
                        addr_d = addr_q + (is_pf || is_blk ? 24'h8 : 24'h2);
                    left_d = left_q - 16'h1;
                    step_d = 2'h1;
                end
            end
            fevc_pkg::FEVC_DONE: begin
                ccf_d = 1'b1;
                st_d = fevc_pkg::FEVC_IDLE;
                irq_st_d[0] = 1'b1;
                if (acc_q) irq_st_d[1] = 1'b1;
                if (vhi_q || vlo_q) irq_st_d[2] = 1'b1;
            end
            default: st_d = fevc_pkg::FEVC_IDLE;
        endcase
        irq_d = |(irq_st_d & irq_en_d);
    end

    // ========================================================
    // state registers
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            cmd0_q <= 16'h0; cmd1_q <= 16'h0; cmd2_q <= 16'h0;
            index_q <= 3'h0; mode_q <= 1'b1;
            ccf_q <= fevc_pkg::RST_CCF; acc_q <= 1'b0;
            vhi_q <= 1'b0; vlo_q <= 1'b0;
            irq_st_q <= '0; irq_en_q <= '0;
            st_q <= fevc_pkg::FEVC_IDLE; req_q <= 1'b0;
            addr_q <= 24'h0; left_q <= 16'h0; step_q <= 2'h0;
            rdata_q <= 32'h0; ready_q <= 1'b0; slverr_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            cmd0_q <= cmd0_d; cmd1_q <= cmd1_d; cmd2_q <= cmd2_d;
            index_q <= index_d; mode_q <= mode_d;
            ccf_q <= ccf_d; acc_q <= acc_d; vhi_q <= vhi_d; vlo_q <= vlo_d;
            irq_st_q <= irq_st_d; irq_en_q <= irq_en_d;
            st_q <= st_d; req_q <= req_d; addr_q <= addr_d;
            left_q <= left_d; step_q <= step_d;
            rdata_q <= rdata_d; ready_q <= ready_d; slverr_q <= slverr_d;
            irq_q <= irq_d;
        end
    end

    assign PRDATA_O   = rdata_q;
    assign PREADY_O   = ready_q;
    assign PSLVERR_O  = slverr_q;
    assign MEM_REQ_O  = req_q;
    assign MEM_ADDR_O = addr_q;
    assign IRQ_O      = irq_q;

    // ========================================================
    // assertions
    logic        sampling;
    assign sampling = st_q == fevc_pkg::FEVC_SCAN && step_q != 2'h0;
    sequence launch_bad_s;
        launch && acc_err && st_q == fevc_pkg::FEVC_IDLE;
    endsequence
    sequence launch_ok_s;
        launch && !acc_err && st_q == fevc_pkg::FEVC_IDLE;
    endsequence
    sequence done_s;
        st_q == fevc_pkg::FEVC_DONE && !ccf_q;
    endsequence
    acc_skip_a: assert property (
        launch_bad_s |=> done_s ##1 ccf_q && acc_q)
        else $error("error launch not skipped");
    launch_clr_a: assert property (
        launch && st_q == fevc_pkg::FEVC_IDLE |=> !ccf_q)
        else $error("launch did not clear complete flag");
    idx_blk_a: assert property (
        launch && is_blk && index_q != fevc_pkg::IDX_BLOCK |=> acc_q)
        else $error("block index error missed");
    idx_sec_a: assert property (
        launch && !is_blk && index_q != fevc_pkg::IDX_SECTION |=> acc_q)
        else $error("section index error missed");
    mode_chk_a: assert property (
        launch && !is_blk && !mode_q |=> acc_q)
        else $error("mode error missed");
    pf_align_a: assert property (
        launch && is_pf && gaddr[2:0] != 3'h0 |=> acc_q)
        else $error("phrase alignment error missed");
    ee_align_a: assert property (
        launch && !is_pf && !is_blk && gaddr[0] |=> acc_q)
        else $error("word alignment error missed");
    map_chk_a: assert property (
        launch && !mapped |=> acc_q)
        else $error("unmapped address error missed");
    pf_range_a: assert property (
        launch && is_pf && {1'b0, gaddr} + span > fevc_pkg::PF_END |=> acc_q)
        else $error("flash boundary error missed");
    ee_range_a: assert property (
        launch && !is_pf && !is_blk
        && {1'b0, gaddr} + span > fevc_pkg::EE_END |=> acc_q)
        else $error("eeprom end error missed");
    blank_fail_a: assert property (
        sampling && !MEM_BLANK_I |=> vhi_q && vlo_q)
        else $error("blank fail not flagged");
    rd_err_a: assert property (
        sampling && MEM_ERR_I |=> vhi_q)
        else $error("read error not flagged");
    uncorr_a: assert property (
        sampling && MEM_UNCORR_I |=> vlo_q)
        else $error("uncorrectable not flagged");
    scan_go_a: assert property (
        launch_ok_s |=> st_q == fevc_pkg::FEVC_SCAN && !ccf_q)
        else $error("clean launch did not start scan");
    first_addr_a: assert property (
        st_q == fevc_pkg::FEVC_SCAN && step_q == 2'h0 && left_q != 16'h0
        |=> req_q && addr_q == $past(addr_q))
        else $error("first request not at start address");
    scan_end_a: assert property (
        st_q == fevc_pkg::FEVC_SCAN && left_q == 16'h0 |=> done_s)
        else $error("scan did not finish");
    done_flag_a: assert property (
        done_s |=> ccf_q && st_q == fevc_pkg::FEVC_IDLE && irq_st_q[0])
        else $error("complete flag not set at end");
    skip_req_a: assert property (
        launch_bad_s |=> !req_q ##1 !req_q)
        else $error("memory read after error launch");
    pf_step_a: assert property (
        req_q && $past(req_q) && (is_pf || is_blk)
        |-> addr_q == $past(addr_q) + 24'h8)
        else $error("phrase step wrong");
    ee_step_a: assert property (
        req_q && $past(req_q) && !is_pf && !is_blk
        |-> addr_q == $past(addr_q) + 24'h2)
        else $error("word step wrong");
endmodule

// file: test/fevc_top_tb_top.sv
/*
 * Self-checking bench for the erase-verify sequencer: APB tasks,
 * command table, interrupt and reset checks.
 * Assumes fevc_pkg and fevc_top compiled first; memory inputs held
 * steady for each command.
 */
`timescale 1ns/1ps
module fevc_top_tb_top;
    logic        clk_i   = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        psel    = 1'b0;
    logic        pen     = 1'b0;
    logic        pwr     = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        blank   = 1'b1;
    logic        merr    = 1'b0;
    logic        munc    = 1'b0;
    logic        mreq;
    logic [23:0] maddr;
    logic        irq;
    logic [31:0] rd_q;
    logic        err_q;
    logic [23:0] first_a;
    logic [31:0] req_n   = 32'h0;
    int          miscompares = 0;
    int          check_count = 0;
    // ========================================================
    // clock, design, request counter
    always #5 clk_i = ~clk_i;
    fevc_top dut_u (.CLK_I(clk_i), .RST_N_I(rst_n_i), .PSEL_I(psel),
        .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr),
        .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .MEM_BLANK_I(blank), .MEM_ERR_I(merr),
        .MEM_UNCORR_I(munc), .MEM_REQ_O(mreq), .MEM_ADDR_O(maddr),
        .IRQ_O(irq));
    always @(posedge clk_i) begin
        if (mreq === 1'b1) begin
            if (req_n == 0) first_a = maddr;
            req_n = req_n + 1;
        end
    end
    // ========================================================
    // shared tasks
    task report_and_stop;
        if (miscompares == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task check(input string nm, input logic [31:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwdata <= d;
        @(posedge clk_i);
        pen <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            miscompares++;
            report_and_stop;
        end
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask
    task run_cmd(input logic [15:0] c0, c1, c2, input logic [2:0] idx,
                 input logic md, bl, er, un, input logic [4:0] st,
                 input logic [31:0] n, input logic [23:0] a);
        int k;
        blank <= bl;
        merr  <= er;
        munc  <= un;
        wr(fevc_pkg::ADDR_MODE, {31'h0, md});
        wr(fevc_pkg::ADDR_CMD0, {16'h0, c0});
        wr(fevc_pkg::ADDR_CMD1, {16'h0, c1});
        wr(fevc_pkg::ADDR_CMD2, {16'h0, c2});
        wr(fevc_pkg::ADDR_INDEX, {29'h0, idx});
        wr(fevc_pkg::ADDR_STAT, 32'h20);
        req_n = 0;
        wr(fevc_pkg::ADDR_STAT, 32'h80);
        k = 0;
        do begin
            rd(fevc_pkg::ADDR_STAT);
            k++;
        end while (rd_q[7] !== 1'b1 && k < 400);
        if (k >= 400) begin
            miscompares++;
            report_and_stop;
        end
        check("status", {27'h0, rd_q[7], rd_q[5:4], rd_q[1:0]}, {27'h0, st});
        check("request count", req_n, n);
        if (n != 0 && n < 256) check("first addr", {8'h0, first_a}, {8'h0, a});
    endtask
    // ========================================================
    // main sequence
    initial begin
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rd(fevc_pkg::ADDR_STAT);
        check("stat reset", rd_q, 32'h80);
        rd(fevc_pkg::ADDR_MODE);
        check("mode reset", rd_q, 32'h1);
        rd(8'h80);
        check("unmapped err", {31'h0, err_q}, 32'h1);
        wr(8'h80, 32'h0);
        check("unmapped wr err", {31'h0, err_q}, 32'h1);
        run_cmd(16'h01e8, 0, 0, 1, 1, 1, 0, 0, 5'h10, 256, 0);
        run_cmd(16'h01e8, 0, 0, 2, 1, 1, 0, 0, 5'h18, 0, 0);
        run_cmd(16'h03e8, 16'h0010, 4, 2, 1, 1, 0, 0, 5'h10, 4,
                24'he80010);
        run_cmd(16'h03e8, 16'h0010, 4, 2, 1, 0, 0, 0, 5'h13, 4,
                24'he80010);
        run_cmd(16'h03e8, 0, 2, 2, 1, 1, 1, 0, 5'h12, 2,
                24'he80000);
        run_cmd(16'h03e8, 0, 2, 2, 1, 1, 1, 1, 5'h13, 2,
                24'he80000);
        run_cmd(16'h03e8, 0, 2, 1, 1, 1, 0, 0, 5'h18, 0, 0);
        run_cmd(16'h03e8, 0, 2, 2, 0, 1, 0, 0, 5'h18, 0, 0);
        run_cmd(16'h0320, 0, 2, 2, 1, 1, 0, 0, 5'h18, 0, 0);
        run_cmd(16'h03e8, 16'h0004, 1, 2, 1, 1, 0, 0, 5'h18, 0, 0);
        run_cmd(16'h03ff, 16'hfff8, 1, 2, 1, 1, 0, 0, 5'h10, 1,
                24'hfffff8);
        run_cmd(16'h03ff, 16'hfff8, 2, 2, 1, 1, 0, 0, 5'h18, 0, 0);
        run_cmd(16'h1010, 0, 3, 2, 1, 1, 0, 0, 5'h10, 3,
                24'h100000);
        run_cmd(16'h1010, 0, 3, 2, 1, 0, 0, 0, 5'h13, 3,
                24'h100000);
        run_cmd(16'h1010, 16'h0001, 1, 2, 1, 1, 0, 0, 5'h18, 0, 0);
        run_cmd(16'h1010, 16'h07fe, 1, 2, 1, 1, 0, 0, 5'h10, 1,
                24'h1007fe);
        run_cmd(16'h1010, 16'h07fe, 2, 2, 1, 1, 0, 0, 5'h18, 0, 0);
        run_cmd(16'h1010, 0, 1, 2, 0, 1, 0, 0, 5'h18, 0, 0);
        run_cmd(16'h1030, 0, 1, 2, 1, 1, 0, 0, 5'h18, 0, 0);
        // interrupt: status, enable mask, clear
        wr(fevc_pkg::ADDR_IRQCLR, 32'h7);
        run_cmd(16'h03e8, 0, 1, 1, 1, 1, 0, 0, 5'h18, 0, 0);
        rd(fevc_pkg::ADDR_IRQST);
        check("irq status err", rd_q, 32'h3);
        wr(fevc_pkg::ADDR_IRQCLR, 32'h7);
        run_cmd(16'h03e8, 0, 1, 2, 1, 0, 0, 0, 5'h13, 1,
                24'he80000);
        rd(fevc_pkg::ADDR_IRQST);
        check("irq status fail", rd_q, 32'h5);
        repeat (2) @(posedge clk_i);
        check("irq masked", {31'h0, irq}, 32'h0);
        wr(fevc_pkg::ADDR_IRQEN, 32'h1);
        repeat (2) @(posedge clk_i);
        check("irq enabled", {31'h0, irq}, 32'h1);
        wr(fevc_pkg::ADDR_IRQCLR, 32'h1);
        repeat (2) @(posedge clk_i);
        check("irq cleared", {31'h0, irq}, 32'h0);
        rd(fevc_pkg::ADDR_IRQST);
        check("irq status left", rd_q, 32'h4);
        report_and_stop;
    end
endmodule
